//--- hdl/asp_baud_gen.sv
// baud generator: prescaler and 16-bit up-counting reload timer
module asp_baud_gen
	import asp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        enable,
	input  wire logic [1:0]  prescale_sel,
	input  wire logic [15:0] reload,
	output logic             tick
);
	logic [5:0]  pre_reg;
	logic [15:0] timer_reg;
	logic [5:0]  pre_limit;
	logic        pre_tick;
	logic        wrap;

	assign pre_limit = (prescale_sel == 2'd0) ? 6'd0 :
			(prescale_sel == 2'd1) ? 6'd3 :
			(prescale_sel == 2'd2) ? 6'd11 : 6'd47; // [RULE9]
	// >= so a smaller ratio picked mid-count ticks at once instead of after a roll-over
	assign pre_tick = enable && (pre_reg >= pre_limit);
	assign wrap = pre_tick && (timer_reg == 16'hFFFF);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_reg   <= 6'd0;
			timer_reg <= 16'h0000;
			tick      <= 1'b0;
		end else begin
			pre_reg <= (!enable || pre_tick) ? 6'd0 : pre_reg + 6'd1; // [RULE8]
			if (!enable)
				timer_reg <= reload;
			else if (wrap)
				timer_reg <= reload; // [RULE14]
			else if (pre_tick)
				timer_reg <= timer_reg + 16'd1; // [RULE13]
			tick <= wrap; // [RULE15]
		end
	end
endmodule

//--- hdl/asp_pkg.sv
// package: register map, field positions and constants of the async serial port
package asp_pkg;
	localparam logic [7:0] ADDR_DATA      = 8'h00;
	localparam logic [7:0] ADDR_CTRL_STAT = 8'h04;
	localparam logic [7:0] ADDR_FORMAT    = 8'h08;
	localparam logic [7:0] ADDR_BAUD_CTRL = 8'h0C;
	localparam logic [7:0] ADDR_RELOAD_HI = 8'h10;
	localparam logic [7:0] ADDR_RELOAD_LO = 8'h14;
	// serial_control_status bits
	localparam int CS_RI   = 0;
	localparam int CS_TI   = 1;
	localparam int CS_REN  = 4;
	localparam int CS_OVR  = 7;
	localparam int CS_PERR = 6;
	// serial_frame_format bits
	localparam int FF_SBL  = 0;
	localparam int FF_DLS  = 1;
	localparam int FF_XBE  = 3;
	localparam int FF_PS   = 4;
	localparam int FF_PE   = 6;
	// baud_gen_control bits
	localparam int BC_PS   = 0;
	localparam int BC_EN   = 6;
	localparam int BC_SRC  = 5;
	localparam logic [7:0] FORMAT_RESET = 8'h0C;
	localparam logic [7:0] BAUD_RESET   = 8'h00;
	localparam int RX_DEPTH   = 3;
	localparam int OVERSAMPLE = 16;
	typedef enum logic [1:0] {
		ASP_PAR_ODD   = 2'b00,
		ASP_PAR_EVEN  = 2'b01,
		ASP_PAR_MARK  = 2'b10,
		ASP_PAR_SPACE = 2'b11
	} asp_parity_t;
	typedef enum logic [2:0] {
		ASP_IDLE   = 3'b000,
		ASP_START  = 3'b001,
		ASP_DATA   = 3'b010,
		ASP_EXTRA  = 3'b011,
		ASP_STOP   = 3'b100
	} asp_state_t;
endpackage

//--- hdl/asp_top.sv
// async serial port with baud generator, apb slave
// Behaviour
// [RULE1] transmitter and receiver run independently at the same time
// [RULE2] receive fifo holds three bytes; more are lost with overflow
// [RULE3] data write loads transmit register only
// [RULE4] data read returns receive fifo; transmit register never readable
// [RULE5] interrupt raised when done flags set and interrupts enabled
// [RULE6] done flags stay set until software writes them clear
// [RULE7] receive-done cannot be cleared while fifo still holds bytes
// [RULE8] baud generator is 16-bit timer from system clock via prescaler
// [RULE9] prescaler divides by 1, 4, 12 or 48
// [RULE10] baud control holds enable, clock source and prescaler select
// [RULE11] serial port idle unless baud generator enabled
// [RULE12] reload value formed from high and low reload registers
// [RULE13] timer increments each prescaled tick from reload
// [RULE14] timer reloads on wrap from all ones to zero
// [RULE15] bit rate is clock over (65536-reload), two and prescaler
// [RULE16] software keeps bit rate at or below clock over sixteen
// [RULE17] frame: low start, 5-8 data lsb first, parity/extra, 1-2 stops
// [RULE18] transmit starts on data write; done flag set at stop start
// [RULE19] parity even/odd/mark/space; no extra with parity; two stops for 6-8
// [RULE20] byte arriving with full fifo is dropped and overflow set
//
// Design decisions made here: the placing of the registers and register access over APB.
module asp_top
	import asp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx_in,
	output logic             tx_out,
	input  wire logic        irq_enable,
	output logic             irq
);
	import asp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// registers and bus decode
	logic [7:0] format_reg;
	logic [7:0] baud_ctrl_reg;
	logic [7:0] reload_hi_reg;
	logic [7:0] reload_lo_reg;
	logic       ti_reg;
	logic       ri_reg;
	logic       ren_reg;
	logic       ovr_reg;
	logic       perr_reg;
	logic       br_tick;
	logic [7:0] rx_fifo [RX_DEPTH];
	logic [1:0] rx_count_reg;
	logic [1:0] rx_rd_reg;
	logic [1:0] rx_wr_reg;

	wire access     = psel && penable;
	wire wr         = access && pwrite;
	wire rd         = access && !pwrite;
	wire hit_data   = (paddr == ADDR_DATA);
	wire hit_cs     = (paddr == ADDR_CTRL_STAT);
	wire hit_fmt    = (paddr == ADDR_FORMAT);
	wire hit_baud   = (paddr == ADDR_BAUD_CTRL);
	wire hit_hi     = (paddr == ADDR_RELOAD_HI);
	wire hit_lo     = (paddr == ADDR_RELOAD_LO);
	// anything else answers with pslverr and ignores writes
	wire mapped     = hit_data | hit_cs | hit_fmt | hit_baud | hit_hi | hit_lo;
	wire wr_data    = wr && hit_data; // [RULE3]
	// a read of an empty fifo pops nothing
	wire rd_data    = rd && hit_data && (rx_count_reg != 2'd0);
	wire wr_cs      = wr && hit_cs;
	wire brg_en     = baud_ctrl_reg[BC_EN]; // [RULE10]
	wire [15:0] reload = {reload_hi_reg, reload_lo_reg}; // [RULE12]

	// frame format decode; extra bit suppressed with parity, 2 stops need 6+ bits
	wire [1:0]  dls      = format_reg[FF_DLS +: 2];
	wire [3:0]  nbits    = 4'd5 + {2'b00, dls};
	wire        par_en   = format_reg[FF_PE];
	wire        xbe      = format_reg[FF_XBE] && !par_en; // [RULE19]
	wire        two_stop = format_reg[FF_SBL] && (dls != 2'd0); // [RULE19]
	wire asp_parity_t ps = asp_parity_t'(format_reg[FF_PS +: 2]);

	function automatic logic par_bit(input logic [7:0] d, input logic [3:0] n,
			input asp_parity_t p, input logic xb);
		logic [7:0] m;
		m = d & ((8'h01 << n) - 8'h01);
		unique case (p)
			ASP_PAR_ODD:   par_bit = ~^m;
			ASP_PAR_EVEN:  par_bit = ^m;
			ASP_PAR_MARK:  par_bit = 1'b1;
			ASP_PAR_SPACE: par_bit = 1'b0;
		endcase
		if (xb)
			par_bit = d[n[2:0]];
	endfunction

	// status word: each flag in its own bit, everything else reads zero
	wire [31:0] cs_word = {24'h0, ovr_reg, perr_reg, 1'b0, ren_reg, 2'b00, ti_reg, ri_reg};
	wire [31:0] rd_mux =
		hit_data ? {24'h0, rx_fifo[rx_rd_reg]} : // [RULE4]
		hit_cs   ? cs_word :
		hit_fmt  ? {24'h0, format_reg} :
		hit_baud ? {24'h0, baud_ctrl_reg} :
		hit_hi   ? {24'h0, reload_hi_reg} :
		hit_lo   ? {24'h0, reload_lo_reg} : 32'h0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			// zero wait states: answer in the first access cycle
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			format_reg    <= FORMAT_RESET;
			baud_ctrl_reg <= BAUD_RESET;
			reload_hi_reg <= 8'h00;
			reload_lo_reg <= 8'h00;
			ren_reg       <= 1'b0;
		end else if (wr && pready) begin
			if (hit_fmt)
				format_reg <= pwdata[7:0];
			// clock source bit is kept for software only; there is a single clock
			if (hit_baud)
				baud_ctrl_reg <= pwdata[7:0];
			if (hit_hi)
				reload_hi_reg <= pwdata[7:0];
			if (hit_lo)
				reload_lo_reg <= pwdata[7:0];
			if (hit_cs)
				ren_reg <= pwdata[CS_REN];
		end
	end

	asp_baud_gen u_baud (
		.clk          (clk),
		.rst_n        (rst_n),
		.enable       (brg_en),
		.prescale_sel (baud_ctrl_reg[BC_PS +: 2]),
		.reload       (reload),
		.tick         (br_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// transmitter: one bit every 2*16 half-bit ticks/16 -> two ticks per bit
	asp_state_t tx_state_reg;
	logic [7:0] tx_shift_reg;
	logic [3:0] tx_cnt_reg;
	logic [4:0] tx_tick_reg;
	logic       tx_bit_end;
	logic       tx_ti_set;
	logic       tx_par_reg;

	// rate = tick/2, so a bit is two wraps; rx likewise samples on every second tick
	assign tx_bit_end = br_tick && tx_tick_reg[0];
	// done flag rises as the stop bit begins
	assign tx_ti_set  = tx_bit_end && (tx_state_reg == ASP_DATA || tx_state_reg == ASP_EXTRA)
			&& (tx_state_reg == ASP_EXTRA || (tx_cnt_reg == nbits - 4'd1 && !par_en && !xbe));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_reg <= ASP_IDLE;
			tx_shift_reg <= 8'h00;
			tx_cnt_reg   <= 4'd0;
			tx_tick_reg  <= 5'd0;
			tx_par_reg   <= 1'b0;
			tx_out       <= 1'b1;
		end else begin
			if (br_tick)
				tx_tick_reg <= tx_tick_reg + 5'd1;
			unique case (tx_state_reg)
				ASP_IDLE: begin
					tx_out <= 1'b1;
					// writes while a frame is on the line are dropped
					if (wr_data && pready && brg_en) begin // [RULE11] [RULE18]
						tx_shift_reg <= pwdata[7:0];
						tx_par_reg   <= par_bit(pwdata[7:0], nbits, ps, xbe);
						tx_cnt_reg   <= 4'd1;
						tx_state_reg <= ASP_START;
					end
				end
				// count 1 marks a start waiting for a tick; the timer runs free,
				// so starting at once would cut the start bit short
				ASP_START: if (tx_cnt_reg != 4'd0) begin
					if (br_tick) begin
						tx_out      <= 1'b0; // [RULE17]
						tx_tick_reg <= 5'd0;
						tx_cnt_reg  <= 4'd0;
					end
				end else if (tx_bit_end) begin
					tx_out       <= tx_shift_reg[0];
					tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
					tx_cnt_reg   <= 4'd0;
					tx_state_reg <= ASP_DATA;
				end
				ASP_DATA: if (tx_bit_end) begin
					tx_cnt_reg <= tx_cnt_reg + 4'd1;
					if (tx_cnt_reg == nbits - 4'd1) begin
						tx_out       <= (par_en || xbe) ? tx_par_reg : 1'b1;
						tx_state_reg <= (par_en || xbe) ? ASP_EXTRA : ASP_STOP;
						tx_cnt_reg   <= 4'd0;
					end else begin
						tx_out       <= tx_shift_reg[0];
						tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
					end
				end
				ASP_EXTRA: if (tx_bit_end) begin
					tx_out       <= 1'b1;
					tx_cnt_reg   <= 4'd0;
					tx_state_reg <= ASP_STOP;
				end
				ASP_STOP: if (tx_bit_end) begin
					tx_cnt_reg <= tx_cnt_reg + 4'd1;
					if (tx_cnt_reg == {3'b000, two_stop})
						tx_state_reg <= ASP_IDLE;
				end
				default: tx_state_reg <= ASP_IDLE;
			endcase
			if (!brg_en)
				tx_state_reg <= ASP_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receiver: start detect, start check on the next baud tick, then a sample every second tick
	asp_state_t rx_state_reg;
	logic [7:0] rx_shift_reg;
	logic [3:0] rx_cnt_reg;
	logic       rx_phase_reg;
	logic       rx_par_reg;
	logic       rx_sample;
	logic       rx_done;
	logic       rx_perr;

	// rx sample point: second tick of each bit after a half-bit start alignment
	assign rx_sample = br_tick && rx_phase_reg;
	assign rx_done   = rx_sample && (rx_state_reg == ASP_STOP) && rx_in;
	assign rx_perr   = par_en && (rx_par_reg != par_bit(rx_shift_reg, nbits, ps, 1'b0));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_state_reg <= ASP_IDLE;
			rx_shift_reg <= 8'h00;
			rx_cnt_reg   <= 4'd0;
			rx_phase_reg <= 1'b0;
			rx_par_reg   <= 1'b0;
		end else begin
			if (br_tick)
				rx_phase_reg <= !rx_phase_reg;
			unique case (rx_state_reg)
				ASP_IDLE: if (!rx_in && ren_reg && brg_en) begin // [RULE1] [RULE11]
					rx_phase_reg <= 1'b0;
					rx_state_reg <= ASP_START;
				end
				ASP_START: if (br_tick && !rx_phase_reg) begin
					// restart the phase so each sample lands two ticks on, inside its bit
					rx_phase_reg <= 1'b0;
					rx_state_reg <= rx_in ? ASP_IDLE : ASP_DATA;
					rx_cnt_reg   <= 4'd0;
					rx_shift_reg <= 8'h00;
				end
				ASP_DATA: if (rx_sample) begin
					rx_shift_reg <= rx_shift_reg | ({7'h0, rx_in} << rx_cnt_reg[2:0]);
					rx_cnt_reg   <= rx_cnt_reg + 4'd1;
					if (rx_cnt_reg == nbits - 4'd1)
						rx_state_reg <= (par_en || xbe) ? ASP_EXTRA : ASP_STOP;
				end
				ASP_EXTRA: if (rx_sample) begin
					rx_par_reg   <= rx_in;
					rx_state_reg <= ASP_STOP;
				end
				ASP_STOP: if (rx_sample)
					rx_state_reg <= ASP_IDLE;
				default: rx_state_reg <= ASP_IDLE;
			endcase
			if (!brg_en)
				rx_state_reg <= ASP_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive fifo and flags
	// full at three: a fourth byte is dropped and flagged as overflow
	wire fifo_full = (rx_count_reg == 2'(RX_DEPTH));
	wire push      = rx_done && !fifo_full; // [RULE2]
	wire ri_clr    = wr_cs && pready && !pwdata[CS_RI];

	// storage needs no reset; the pointers and count decide what is valid
	always_ff @(posedge clk) begin
		if (push)
			rx_fifo[rx_wr_reg] <= rx_shift_reg;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_count_reg <= 2'd0;
			rx_rd_reg    <= 2'd0;
			rx_wr_reg    <= 2'd0;
		end else begin
			if (push)
				rx_wr_reg <= (rx_wr_reg == 2'(RX_DEPTH - 1)) ? 2'd0 : rx_wr_reg + 2'd1;
			if (rd_data && pready)
				rx_rd_reg <= (rx_rd_reg == 2'(RX_DEPTH - 1)) ? 2'd0 : rx_rd_reg + 2'd1;
			rx_count_reg <= rx_count_reg + {1'b0, push} - {1'b0, rd_data && pready};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ti_reg   <= 1'b0;
			ri_reg   <= 1'b0;
			ovr_reg  <= 1'b0;
			perr_reg <= 1'b0;
			irq      <= 1'b0;
		end else begin
			// set wins over a coincident software clear
			if (tx_ti_set)
				ti_reg <= 1'b1; // [RULE18]
			else if (wr_cs && pready && !pwdata[CS_TI])
				ti_reg <= 1'b0; // [RULE6]
			// receive-done only clears once the fifo is empty
			if (push)
				ri_reg <= 1'b1;
			else if (ri_clr && rx_count_reg <= 2'd1 && !(rd_data && pready) && rx_count_reg == 2'd0)
				ri_reg <= 1'b0; // [RULE7]
			if (rx_done && fifo_full)
				ovr_reg <= 1'b1; // [RULE20]
			else if (wr_cs && pready && !pwdata[CS_OVR])
				ovr_reg <= 1'b0;
			if (push && rx_perr)
				perr_reg <= 1'b1; // [RULE19]
			else if (wr_cs && pready && !pwdata[CS_PERR])
				perr_reg <= 1'b0;
			// level output, one clock behind the flags
			irq <= irq_enable && (ti_reg || ri_reg); // [RULE5]
		end
	end
endmodule

//--- tb/asp_assertions.sv
// checker: apb handshake, error response and interrupt gating of the serial port
module asp_assertions
	import asp_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rx_in,
	input wire logic        tx_out,
	input wire logic        irq_enable,
	input wire logic        irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// address held through access, so decode is valid while pready is high
	wire bad_addr = (paddr > ADDR_RELOAD_LO) || (paddr[1:0] != 2'b00);
	////////////////////////////////////////////////////////////////
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_err_unmapped: assert property (pready && bad_addr |-> pslverr)
		else $error("unmapped address accepted");
	a_mapped_no_err: assert property (pready && !bad_addr |-> !pslverr)
		else $error("mapped address refused");
	a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	a_irq_masked: assert property (!irq_enable |=> !irq)
		else $error("irq while disabled");
	cover property (pslverr);
	cover property ($rose(irq));
	cover property ($fell(tx_out));
endmodule
////////////////////////////////////////////////////////////////
bind asp_top asp_assertions u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in(rx_in),
	.tx_out(tx_out), .irq_enable(irq_enable), .irq(irq));

//--- tb/asp_partner.sv
// partner: behavioural serial node facing the transmit and receive lines
module asp_partner (
	input  wire logic clk,
	input  wire logic tx_out,
	output logic      rx_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// never below sixteen clocks a bit
	int         bit_cyc = 16;
	logic [8:0] got_q[$];
	initial rx_line = 1'b1;
	// start low, eight data lsb first, one high stop; line idles high
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			rx_line <= f[i];
			repeat (bit_cyc - 1) @(posedge clk);
		end
	endtask
	// samples mid-bit; the ninth bit (stop, or parity when enabled) is kept as bit 8 of each capture
	initial begin
		logic [8:0] v;
		forever begin
			@(negedge tx_out);
			repeat (bit_cyc / 2) @(posedge clk);
			for (int i = 0; i < 9; i++) begin
				repeat (bit_cyc) @(posedge clk);
				v[i] = tx_out;
			end
			got_q.push_back(v);
		end
	end
endmodule

//--- tb/async_serial_port_baud_gen_bench.sv
// bench: registers, transmit at each prescale, receive fifo and interrupt
module async_serial_port_baud_gen_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import asp_pkg::*;
	localparam int RLD = 'hFFF8;
	logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic        irq_enable = 0, pready, pslverr, rx_in, tx_out, irq, err, par;
	logic [7:0]  paddr = 0, b;
	logic [31:0] pwdata = 0, prdata, rd, e;
	int          num_errors = 0, n_checks = 0, cyc = 0, seed = 32'hddaf;
	int          ratio[4] = '{1, 4, 12, 48};
	// 8 data bits, one stop: parity off, even, odd, mark
	logic [31:0] fmt[4] = '{32'h0000_0006, 32'h0000_0056, 32'h0000_0046, 32'h0000_0066};
	int          mq[$];
	initial forever #12.5 clk = ~clk;
	asp_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out),
		.irq_enable(irq_enable), .irq(irq));
	asp_partner FAR (.clk(clk), .tx_out(tx_out), .rx_line(rx_in));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
		n_checks++;
		if (g !== x) begin
			num_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, x);
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// waits for the slave however long it takes, up to the bench limit
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_frame(input logic [8:0] x);
		for (int n = 0; n < 12 * FAR.bit_cyc && FAR.got_q.size() == 0; n++)
			@(posedge clk);
		chk(FAR.got_q.size(), 1, "frame count");
		if (FAR.got_q.size() > 0)
			chk(FAR.got_q.pop_front(), x, "frame");
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		apb(0, ADDR_FORMAT, 0);
		chk(rd, {24'h0, FORMAT_RESET}, "format reset");
		apb(0, ADDR_BAUD_CTRL, 0);
		chk(rd, {24'h0, BAUD_RESET}, "baud reset");
		apb(0, 8'h18, 0);
		chk({err, rd[30:0]}, 32'h8000_0000, "unmapped");
		apb(1, ADDR_FORMAT, 32'h0000_0006);
		apb(1, ADDR_RELOAD_HI, RLD >> 8);
		apb(1, ADDR_RELOAD_LO, RLD & 'hFF);
		apb(0, ADDR_RELOAD_LO, 0);
		chk(rd, 32'h0000_00F8, "reload low");
		apb(1, ADDR_CTRL_STAT, 1 << CS_REN);
		apb(1, ADDR_DATA, 32'h0000_0055);
		repeat (400) @(posedge clk);
		chk(FAR.got_q.size(), 0, "sent while disabled");
		$display("test registers done");
		for (int ps = 0; ps < 4; ps++) begin
			FAR.bit_cyc = 2 * (65536 - RLD) * ratio[ps];
			e = (1 << BC_EN) | (1 << BC_SRC) | ps;
			apb(1, ADDR_BAUD_CTRL, e);
			apb(0, ADDR_BAUD_CTRL, 0);
			chk(rd, e, "baud control");
			apb(1, ADDR_FORMAT, fmt[ps]);
			b = 8'($random(seed));
			// ninth bit on the line: stop, even, odd or mark parity
			par = (ps == 1) ? ^b : (ps == 2) ? ~^b : 1'b1;
			apb(1, ADDR_DATA, {24'h0, b});
			wait_frame({par, b});
			// let the stop bit end before status is read or the next write
			repeat (2 * FAR.bit_cyc) @(posedge clk);
			apb(0, ADDR_CTRL_STAT, 0);
			chk(rd, (1 << CS_REN) | (1 << CS_TI), "tx done");
			chk({31'h0, irq}, 0, "irq masked");
			irq_enable <= 1'b1;
			repeat (2) @(posedge clk);
			chk({31'h0, irq}, 1, "irq raised");
			apb(1, ADDR_CTRL_STAT, 1 << CS_REN);
			repeat (2) @(posedge clk);
			chk({31'h0, irq}, 0, "irq cleared");
			irq_enable <= 1'b0;
		end
		$display("test transmit done");
		apb(1, ADDR_FORMAT, 32'h0000_0006);
		FAR.bit_cyc = 2 * (65536 - RLD);
		apb(1, ADDR_BAUD_CTRL, 1 << BC_EN);
		b = 8'($random(seed));
		fork
			apb(1, ADDR_DATA, {24'h0, b});
			for (int i = 0; i < 4; i++) begin
				mq.push_back($random(seed) & 'hFF);
				FAR.send(mq[i]);
			end
		join
		repeat (32) @(posedge clk);
		wait_frame({1'b1, b});
		apb(0, ADDR_CTRL_STAT, 0);
		chk(rd, 32'h0000_0093, "fifo overflow");
		for (int i = 0; i < RX_DEPTH; i++) begin
			apb(0, ADDR_DATA, 0);
			chk(rd, mq[i], "rx byte");
			apb(1, ADDR_CTRL_STAT, 1 << CS_REN);
			apb(0, ADDR_CTRL_STAT, 0);
			chk(rd, (1 << CS_REN) | (i < 2), "rx done clear");
		end
		$display("test receive done");
		summarize();
	end
endmodule
